// ---- pfwec_core.sv ----
// Program flash write and erase sequencer with its register file.
//
// Function
// - Key register is write-only, eight bits, only guards against accidents.
// - Target address is upper eight bits joined above lower sixteen.
// - Row programming fetches RAM data from the source address register.
// - Start bit launches operation; hardware clears it on completion.
// - Software can only set the start bit, never clear it.
// - Permit bit allows program and erase only when one.
// - Sequence error flag set on improper sequence or premature termination.
// - Standby bit puts regulator to standby in idle, wake delay after.
// - Packing bit selects compressed or uncompressed row layout in RAM.
// - Underrun flag set when row programming stops for lack of data.
// - Operation codes: 3 page erase, 2 row program, 1 double-word.
// - Double-word program writes two adjacent words on two-word boundary.
// - Start, permit, error and operation bits reset only on power-on.
// - Power-save instruction is ignored while an operation runs.
// - Both target address registers read and write, undefined after reset.
// - Unused upper bits of upper target and key registers read zero.
// - Row program loads 64 words (128 bytes), stepping source and target addresses.
// - Page erase clears eight rows, 512 instructions, page aligned.
// - Processor stalls until a started operation finishes.
module pfwec_core #(
	parameter int BURN_CYCLES = 16
) (
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        por_n_in,
	input  wire logic [2:0]  reg_addr_in,
	input  wire logic [15:0] reg_wdata_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	output logic      [15:0] reg_rdata_out,
	input  wire logic        idle_mode_in,
	input  wire logic        power_save_instruction_in,
	output logic             power_save_grant_out,
	output logic             regulator_standby_out,
	output logic             flash_ready_out,
	output logic             cpu_stall_out,
	output logic             done_irq_out,
	output logic      [15:0] ram_addr_out,
	output logic             ram_rd_out,
	input  wire logic [15:0] ram_data_in,
	input  wire logic        ram_valid_in,
	output logic      [23:0] flash_addr_out,
	output logic      [15:0] flash_wdata_out,
	output logic             flash_wr_out,
	output logic             flash_erase_out,
	output logic             row_packing_out
);

	// The burn counter is sixteen bits wide, so the count must fit in it.
	if (BURN_CYCLES < 1 || BURN_CYCLES > 32'h0000ffff) begin : g_bad_burn
		$error("BURN_CYCLES must lie between one and 65535");
	end

	////////////////////////////////////////////////////////////////////////
	// Registers and state.

	pfwec_pkg::pfwec_state_e state_r;
	logic        start_r;
	logic        permit_r;
	logic        seqerr_r;
	logic        standby_r;
	logic        packing_r;
	logic        underrun_r;
	logic [3:0]  opsel_r;
	logic [15:0] tgt_low_r;
	logic [7:0]  tgt_high_r;
	logic [15:0] src_low_r;
	logic [15:0] src_high_r;
	logic [1:0]  key_stage_r;
	logic [6:0]  words_left_r;
	logic [15:0] burn_cnt_r;
	logic [7:0]  wake_cnt_r;
	logic        idle_prev_r;
	logic        wr_ctl;
	logic        start_req;
	logic        start_ok;
	logic        op_valid;
	logic        busy;

	// Legal operation codes; used only by the start check.
	function automatic logic op_known(input logic [3:0] op);
		return op == pfwec_pkg::OP_PAGE_ERASE ||
			op == pfwec_pkg::OP_ROW_PROGRAM ||
			op == pfwec_pkg::OP_DWORD_PROG;
	endfunction

	assign wr_ctl    = reg_wr_in && reg_addr_in == pfwec_pkg::ADDR_CONTROL;
	assign start_req = wr_ctl && reg_wdata_in[pfwec_pkg::BIT_START] && !start_r;
	assign op_valid  = op_known(reg_wdata_in[pfwec_pkg::OPSEL_MSB:0]);
	assign start_ok  = start_req && reg_wdata_in[pfwec_pkg::BIT_PERMIT] &&
		key_stage_r == 2'h2 && op_valid;
	assign busy      = state_r != pfwec_pkg::ST_IDLE;

	////////////////////////////////////////////////////////////////////////
	// Unlock key tracking: a key write must be followed straight away.

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			key_stage_r <= 2'h0;
		end else if (reg_wr_in && reg_addr_in == pfwec_pkg::ADDR_KEY) begin
			if (reg_wdata_in[7:0] == pfwec_pkg::KEY_FIRST) begin
				key_stage_r <= 2'h1;
			end else if (key_stage_r == 2'h1 &&
					reg_wdata_in[7:0] == pfwec_pkg::KEY_SECOND) begin
				key_stage_r <= 2'h2;
			end else begin
				key_stage_r <= 2'h0;
			end
		end else if (reg_wr_in || reg_rd_in) begin
			// Any other access breaks the consecutive pattern.
			key_stage_r <= 2'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Power-on-only control bits; a system reset leaves them untouched.

	always_ff @(posedge clk_in) begin
		if (!por_n_in) begin
			start_r  <= 1'b0;
			permit_r <= 1'b0;
			seqerr_r <= 1'b0;
			opsel_r  <= 4'h0;
		end else begin
			if (wr_ctl) begin
				permit_r <= reg_wdata_in[pfwec_pkg::BIT_PERMIT];
				// Opcode is frozen while an operation runs.
				if (!start_r) begin
					opsel_r <= reg_wdata_in[pfwec_pkg::OPSEL_MSB:0];
				end
			end
			// set by software, cleared by hardware
			if (start_ok) begin
				start_r <= 1'b1;
			end else if (state_r == pfwec_pkg::ST_DONE) begin
				start_r <= 1'b0;
			end
			// error flag, set wins over clear
			if (start_req && !start_ok) begin
				seqerr_r <= 1'b1;
			end else if (state_r == pfwec_pkg::ST_LOAD && ram_rd_out &&
					!ram_valid_in) begin
				seqerr_r <= 1'b1;
			end else if (start_ok) begin
				seqerr_r <= 1'b0;
			end else if (wr_ctl && !reg_wdata_in[pfwec_pkg::BIT_SEQERR]) begin
				seqerr_r <= 1'b0;
			end
		end
	end

	// Plain control bits and the clearable underrun flag.
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			standby_r  <= 1'b0;
			packing_r  <= 1'b0;
			underrun_r <= 1'b0;
		end else begin
			if (wr_ctl) begin
				standby_r <= reg_wdata_in[pfwec_pkg::BIT_STANDBY];
				packing_r <= reg_wdata_in[pfwec_pkg::BIT_PACKING];
			end
			if (state_r == pfwec_pkg::ST_LOAD && ram_rd_out && !ram_valid_in &&
					opsel_r == pfwec_pkg::OP_ROW_PROGRAM) begin
				underrun_r <= 1'b1;
			end else if (wr_ctl && !reg_wdata_in[pfwec_pkg::BIT_UNDERRUN]) begin
				underrun_r <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Address registers: source stepped by hardware during row programming, target during every word load.

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			src_low_r  <= 16'h0000;
			src_high_r <= 16'h0000;
		end else if (state_r == pfwec_pkg::ST_LOAD && ram_valid_in &&
				opsel_r == pfwec_pkg::OP_ROW_PROGRAM) begin
			src_low_r <= src_low_r + pfwec_pkg::RAM_STEP;
		end else if (reg_wr_in && !busy) begin
			if (reg_addr_in == pfwec_pkg::ADDR_SRC_LOW) begin
				src_low_r <= reg_wdata_in;
			end
			if (reg_addr_in == pfwec_pkg::ADDR_SRC_HIGH) begin
				src_high_r <= reg_wdata_in;
			end
		end
	end

	// Target address has no reset: its content is undefined until written.
	always_ff @(posedge clk_in) begin
		if (busy && state_r == pfwec_pkg::ST_LOAD && ram_valid_in) begin
			{tgt_high_r, tgt_low_r} <= {tgt_high_r, tgt_low_r} +
				pfwec_pkg::WORD_STEP;
		end else if (start_ok && reg_wdata_in[pfwec_pkg::OPSEL_MSB:0] ==
				pfwec_pkg::OP_DWORD_PROG) begin
			tgt_low_r[1:0] <= pfwec_pkg::DWORD_ALIGN;
		end else if (reg_wr_in && !busy) begin
			if (reg_addr_in == pfwec_pkg::ADDR_TGT_LOW) begin
				tgt_low_r <= reg_wdata_in;
			end
			if (reg_addr_in == pfwec_pkg::ADDR_TGT_HIGH) begin
				tgt_high_r <= reg_wdata_in[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Operation sequencer: load words, burn, finish.

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			state_r      <= pfwec_pkg::ST_IDLE;
			words_left_r <= 7'h00;
			burn_cnt_r   <= 16'h0000;
		end else begin
			case (state_r)
				pfwec_pkg::ST_IDLE: begin
					if (start_ok) begin
						if (reg_wdata_in[3:0] == pfwec_pkg::OP_ROW_PROGRAM) begin
							words_left_r <= pfwec_pkg::ROW_WORDS;
						end else begin
							words_left_r <= pfwec_pkg::DWORD_WORDS;
						end
						if (reg_wdata_in[3:0] == pfwec_pkg::OP_PAGE_ERASE) begin
							state_r <= pfwec_pkg::ST_BURN;
						end else begin
							state_r <= pfwec_pkg::ST_LOAD;
						end
						burn_cnt_r <= 16'(BURN_CYCLES);
					end
				end
				pfwec_pkg::ST_LOAD: begin
					if (ram_rd_out && !ram_valid_in) begin
						// Premature end: flags raised elsewhere.
						state_r <= pfwec_pkg::ST_DONE;
					end else if (ram_valid_in) begin
						words_left_r <= words_left_r - 7'h01;
						if (words_left_r == 7'h01) begin
							state_r <= pfwec_pkg::ST_BURN;
						end
					end
				end
				pfwec_pkg::ST_BURN: begin
					burn_cnt_r <= burn_cnt_r - 16'h0001;
					if (burn_cnt_r == 16'h0001) begin
						state_r <= pfwec_pkg::ST_DONE;
					end
				end
				pfwec_pkg::ST_DONE: begin
					state_r <= pfwec_pkg::ST_IDLE;
				end
				default: begin
					state_r <= pfwec_pkg::ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Flash and RAM side outputs, all registered.

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			ram_addr_out    <= 16'h0000;
			ram_rd_out      <= 1'b0;
			flash_addr_out  <= 24'h000000;
			flash_wdata_out <= 16'h0000;
			flash_wr_out    <= 1'b0;
			flash_erase_out <= 1'b0;
			row_packing_out <= 1'b0;
		end else begin
			// RAM fetch from source; rows step it, double words read one address twice
			ram_rd_out   <= state_r == pfwec_pkg::ST_LOAD && !ram_valid_in &&
				!ram_rd_out;
			ram_addr_out <= src_low_r;
			flash_wr_out <= state_r == pfwec_pkg::ST_LOAD && ram_valid_in;
			flash_wdata_out <= ram_data_in;
			// double-word alignment forced to two-word boundary (four address units)
			if (opsel_r == pfwec_pkg::OP_DWORD_PROG &&
					state_r == pfwec_pkg::ST_IDLE) begin
				flash_addr_out <= {tgt_high_r, tgt_low_r[15:2],
					pfwec_pkg::DWORD_ALIGN};
			end else if (opsel_r == pfwec_pkg::OP_PAGE_ERASE) begin
				flash_addr_out <= {tgt_high_r, tgt_low_r} & pfwec_pkg::PAGE_MASK;
			end else begin
				flash_addr_out <= {tgt_high_r, tgt_low_r};
			end
			flash_erase_out <= state_r == pfwec_pkg::ST_BURN &&
				opsel_r == pfwec_pkg::OP_PAGE_ERASE;
			row_packing_out <= packing_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Core handshakes: stall, completion pulse, power save, regulator.

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			cpu_stall_out         <= 1'b0;
			done_irq_out          <= 1'b0;
			power_save_grant_out  <= 1'b0;
			regulator_standby_out <= 1'b0;
			flash_ready_out       <= 1'b0;
			wake_cnt_r            <= 8'h00;
			idle_prev_r           <= 1'b0;
		end else begin
			cpu_stall_out <= start_ok || (busy && state_r != pfwec_pkg::ST_DONE);
			done_irq_out <= state_r == pfwec_pkg::ST_DONE;
			power_save_grant_out <= power_save_instruction_in && !busy &&
				!start_r;
			idle_prev_r <= idle_mode_in;
			regulator_standby_out <= idle_mode_in && standby_r;
			if (idle_mode_in && standby_r) begin
				wake_cnt_r <= 8'(pfwec_pkg::WAKE_CYCLES);
			end else if (wake_cnt_r != 8'h00) begin
				wake_cnt_r <= wake_cnt_r - 8'h01;
			end
			flash_ready_out <= !(idle_mode_in && standby_r) &&
				wake_cnt_r <= 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data, one cycle after the read strobe; key reads as zero.

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			reg_rdata_out <= 16'h0000;
		end else if (reg_rd_in) begin
			case (reg_addr_in)
				pfwec_pkg::ADDR_CONTROL: reg_rdata_out <= {start_r, permit_r,
					seqerr_r, standby_r, 2'h0, packing_r, underrun_r, 4'h0,
					opsel_r};
				pfwec_pkg::ADDR_TGT_LOW:  reg_rdata_out <= tgt_low_r;
				pfwec_pkg::ADDR_TGT_HIGH: reg_rdata_out <= {8'h00, tgt_high_r};
				pfwec_pkg::ADDR_SRC_LOW:  reg_rdata_out <= src_low_r;
				pfwec_pkg::ADDR_SRC_HIGH: reg_rdata_out <= src_high_r;
				default:                  reg_rdata_out <= 16'h0000;
			endcase
		end else begin
			reg_rdata_out <= 16'h0000;
		end
	end

endmodule // pfwec_core

// ---- pfwec_pkg.sv ----
// Constants and types for the program flash write and erase sequencer.
package pfwec_pkg;

	// Register indices on the plain register port.
	localparam logic [2:0] ADDR_CONTROL  = 3'h0;
	localparam logic [2:0] ADDR_TGT_LOW  = 3'h1;
	localparam logic [2:0] ADDR_TGT_HIGH = 3'h2;
	localparam logic [2:0] ADDR_KEY      = 3'h3;
	localparam logic [2:0] ADDR_SRC_LOW  = 3'h4;
	localparam logic [2:0] ADDR_SRC_HIGH = 3'h5;

	// Control register field positions.
	localparam int BIT_START   = 15;
	localparam int BIT_PERMIT  = 14;
	localparam int BIT_SEQERR  = 13;
	localparam int BIT_STANDBY = 12;
	localparam int BIT_PACKING = 9;
	localparam int BIT_UNDERRUN = 8;
	localparam int OPSEL_MSB   = 3;

	// Operation codes.
	localparam logic [3:0] OP_PAGE_ERASE  = 4'h3;
	localparam logic [3:0] OP_ROW_PROGRAM = 4'h2;
	localparam logic [3:0] OP_DWORD_PROG  = 4'h1;

	// Unlock key values.
	localparam logic [7:0] KEY_FIRST  = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'haa;

	// Geometry: words per row and per double-word write.
	localparam logic [6:0] ROW_WORDS   = 7'h40;
	localparam logic [6:0] DWORD_WORDS = 7'h02;
	localparam logic [1:0] DWORD_ALIGN = 2'h0;
	// Program addresses step by two per instruction word.
	localparam logic [23:0] WORD_STEP  = 24'h000002;
	// Page is 512 instructions, 1024 address units.
	localparam logic [23:0] PAGE_MASK  = 24'hfffc00;
	localparam logic [15:0] RAM_STEP   = 16'h0002;

	// Regulator wake delay in nanoseconds and in clock cycles.
	localparam int CLK_PERIOD_NS  = 4;
	localparam int WAKE_DELAY_NS  = 40;
	localparam int WAKE_CYCLES    = (WAKE_DELAY_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_LOAD  = 3'b001,
		ST_BURN  = 3'b011,
		ST_DONE  = 3'b010
	} pfwec_state_e;

endpackage

// ---- pfwec_ram_model.sv ----
// Source RAM model that answers row data fetches.
module pfwec_ram_model (
	input  wire logic        clk_in,
	input  wire logic        ram_rd_in,
	input  wire logic [15:0] ram_addr_in,
	input  wire logic        starve_in,
	output logic      [15:0] ram_data_out,
	output logic             ram_valid_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] junk_r = 16'h0000;
	// The sequencer takes the answer in the cycle its fetch strobe stands,
	// so valid and data are combinational. Data follows the address so a
	// wrong fetch shows up; between answers the bus toggles.
	assign ram_valid_out = ram_rd_in && !starve_in;
	assign ram_data_out  = ram_valid_out ? ram_addr_in ^ 16'h5a3c : junk_r;
	always @(posedge clk_in)
		junk_r <= ~junk_r;
endmodule // pfwec_ram_model

// ---- pfwec_checker.sv ----
// Port level assertions for the flash sequencer.
module pfwec_checker (
	input wire logic        clk_in,
	input wire logic        rst_n_in,
	input wire logic        por_n_in,
	input wire logic [2:0]  reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic        reg_wr_in,
	input wire logic        reg_rd_in,
	input wire logic [15:0] reg_rdata_out,
	input wire logic        idle_mode_in,
	input wire logic        power_save_instruction_in,
	input wire logic        power_save_grant_out,
	input wire logic        regulator_standby_out,
	input wire logic        flash_ready_out,
	input wire logic        cpu_stall_out,
	input wire logic        done_irq_out,
	input wire logic        ram_rd_out,
	input wire logic        flash_wr_out,
	input wire logic        flash_erase_out
);
	// System reset forces every output low; checks rest during either reset.
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in || !por_n_in);
	////////////////////////////////////////////////////////////////////
	property p_rd_idle;
		!$past(reg_rd_in) |-> reg_rdata_out == 16'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data not zero");
	property p_key_zero;
		$past(reg_rd_in) && $past(reg_addr_in) == pfwec_pkg::ADDR_KEY
			|-> reg_rdata_out == 16'h0;
	endproperty
	a_key_zero: assert property (p_key_zero)
		else $error("key read not zero");
	property p_start;
		$rose(cpu_stall_out) |-> $past(reg_wr_in) && $past(reg_wdata_in[15])
			&& $past(reg_wdata_in[14])
			&& $past(reg_addr_in) == pfwec_pkg::ADDR_CONTROL;
	endproperty
	a_start: assert property (p_start)
		else $error("stall without start write");
	property p_busy;
		flash_wr_out || flash_erase_out || ram_rd_out |-> cpu_stall_out;
	endproperty
	a_busy: assert property (p_busy)
		else $error("flash activity without stall");
	property p_done;
		done_irq_out |-> $past(cpu_stall_out) ##1 !done_irq_out;
	endproperty
	a_done: assert property (p_done)
		else $error("bad completion pulse");
	property p_grant;
		power_save_grant_out |-> $past(power_save_instruction_in);
	endproperty
	a_grant: assert property (p_grant)
		else $error("grant without request");
	property p_no_grant;
		cpu_stall_out && $past(cpu_stall_out) |-> !power_save_grant_out;
	endproperty
	a_no_grant: assert property (p_no_grant)
		else $error("grant while busy");
	property p_standby;
		!$past(idle_mode_in) |-> !regulator_standby_out;
	endproperty
	a_standby: assert property (p_standby)
		else $error("standby outside idle");
	property p_ready;
		regulator_standby_out && $past(regulator_standby_out)
			|-> !flash_ready_out;
	endproperty
	a_ready: assert property (p_ready)
		else $error("ready during standby");
endmodule // pfwec_checker

// ---- program_flash_write_erase_control_bench.sv ----
// Self-checking bench for the flash write and erase sequencer.
module program_flash_write_erase_control_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BURN = 4;
	logic        clk_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic        por_n_in = 1'b0;
	logic [2:0]  reg_addr_in = 3'h0;
	logic [15:0] reg_wdata_in = 16'h0;
	logic        reg_wr_in = 1'b0;
	logic        reg_rd_in = 1'b0;
	logic        idle_mode_in = 1'b0;
	logic        power_save_instruction_in = 1'b0;
	logic        starve = 1'b0;
	logic [15:0] reg_rdata_out, ram_addr_out, ram_data_in, flash_wdata_out;
	logic [23:0] flash_addr_out, tgt;
	logic        power_save_grant_out, regulator_standby_out, flash_ready_out;
	logic        cpu_stall_out, done_irq_out, ram_rd_out, ram_valid_in;
	logic        flash_wr_out, flash_erase_out, row_packing_out;
	logic [15:0] src;
	logic [39:0] exp_q[$];
	logic [3:0]  ops[3] = '{4'h3, 4'h1, 4'h2};
	int          nw[3] = '{0, 2, 64};
	int          fail_count = 0;
	int          tests_run = 0;
	int          wr_seen = 0;
	int          er_seen = 0;

	pfwec_core #(.BURN_CYCLES(BURN)) DUT (.*);
	pfwec_ram_model u_ram (.clk_in(clk_in), .ram_rd_in(ram_rd_out),
		.ram_addr_in(ram_addr_out), .starve_in(starve),
		.ram_data_out(ram_data_in), .ram_valid_out(ram_valid_in));

	// Free running 250 MHz clock.
	always #2 clk_in = ~clk_in;
	////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %0t saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Write strobe stays up between back to back writes; rd and idle drop it.
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		reg_wr_in <= 1'b1;
		reg_rd_in <= 1'b0;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge clk_in);
	endtask
	task automatic idle();
		reg_wr_in <= 1'b0;
		reg_rd_in <= 1'b0;
		@(posedge clk_in);
	endtask
	task automatic rd(input logic [2:0] a, input logic [15:0] exp);
		reg_rd_in <= 1'b1;
		reg_wr_in <= 1'b0;
		reg_addr_in <= a;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		#1 chk(24'(reg_rdata_out), 24'(exp));
		@(posedge clk_in);
	endtask
	task automatic launch(input logic [15:0] c, input bit gap);
		int n = 0;
		// unlock keys; any write between them breaks the unlock.
		wr(pfwec_pkg::ADDR_KEY, 16'(pfwec_pkg::KEY_FIRST));
		if (gap)
			wr(pfwec_pkg::ADDR_SRC_HIGH, 16'h0000);
		wr(pfwec_pkg::ADDR_KEY, 16'(pfwec_pkg::KEY_SECOND));
		wr(pfwec_pkg::ADDR_CONTROL, c);
		idle();
		@(posedge clk_in);
		while (cpu_stall_out !== 1'b0 && n < 500) begin
			@(posedge clk_in);
			n++;
		end
		if (n >= 500) begin
			chk(24'h1, 24'h0);
			close_out();
		end
	endtask
	////////////////////////////////////////////////////////////////////
	// Random power-save requests, also while an operation runs.
	always @(posedge clk_in)
		power_save_instruction_in <= 1'($urandom_range(1));
	// Each programmed word must match the next address and RAM word.
	always @(posedge clk_in) begin
		if (flash_erase_out === 1'b1) begin
			er_seen++;
			chk(flash_addr_out, tgt & pfwec_pkg::PAGE_MASK);
		end
		if (flash_wr_out === 1'b1) begin
			wr_seen++;
			if (exp_q.size() == 0)
				chk(24'h1, 24'h0);
			else begin
				chk(flash_addr_out, exp_q[0][39:16]);
				chk(24'(flash_wdata_out), 24'(exp_q[0][15:0]));
				void'(exp_q.pop_front());
			end
		end
	end
	////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		void'($urandom(89));
		repeat (8) @(posedge clk_in);
		rst_n_in <= 1'b1;
		por_n_in <= 1'b1;
		@(posedge clk_in);
		rd(pfwec_pkg::ADDR_CONTROL, 16'h0000);
		rd(pfwec_pkg::ADDR_SRC_LOW, 16'h0000);
		rd(pfwec_pkg::ADDR_SRC_HIGH, 16'h0000);
		rd(3'h6, 16'h0000);
		wr(pfwec_pkg::ADDR_KEY, 16'h1255);
		rd(pfwec_pkg::ADDR_KEY, 16'h0000);
		launch(16'hc002, 1'b1);
		rd(pfwec_pkg::ADDR_CONTROL, 16'h6002);
		launch(16'h8002, 1'b0);
		rd(pfwec_pkg::ADDR_CONTROL, 16'h2002);
		launch(16'hc005, 1'b0);
		rd(pfwec_pkg::ADDR_CONTROL, 16'h6005);
		for (int k = 0; k < 3; k++) begin
			// row aligned targets sit on 64-word boundaries.
			tgt = 24'($urandom) & 24'h3fff80;
			src = 16'($urandom) & 16'h7ffe;
			wr(pfwec_pkg::ADDR_TGT_LOW, tgt[15:0]);
			wr(pfwec_pkg::ADDR_TGT_HIGH, 16'hff00 | 16'(tgt[23:16]));
			wr(pfwec_pkg::ADDR_SRC_LOW, src);
			wr(pfwec_pkg::ADDR_SRC_HIGH, 16'h0000);
			rd(pfwec_pkg::ADDR_TGT_LOW, tgt[15:0]);
			rd(pfwec_pkg::ADDR_TGT_HIGH, 16'(tgt[23:16]));
			// Only a row steps the source; a double word reads one address.
			for (int i = 0; i < nw[k]; i++)
				exp_q.push_back({tgt + pfwec_pkg::WORD_STEP * 24'(i),
					(src + pfwec_pkg::RAM_STEP * 16'(nw[k] > 2 ? i : 0))
					^ 16'h5a3c});
			wr_seen = 0;
			er_seen = 0;
			launch(16'hc000 | 16'(ops[k]), 1'b0);
			chk(24'(wr_seen), 24'(nw[k]));
			chk(24'(er_seen != 0), 24'(ops[k] == 4'h3));
			rd(pfwec_pkg::ADDR_CONTROL, 16'h4000 | 16'(ops[k]));
		end
		starve <= 1'b1;
		launch(16'hc002, 1'b0);
		starve <= 1'b0;
		rd(pfwec_pkg::ADDR_CONTROL, 16'h6102);
		wr(pfwec_pkg::ADDR_CONTROL, 16'h5202);
		rd(pfwec_pkg::ADDR_CONTROL, 16'h5202);
		idle_mode_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		#1 chk(24'(regulator_standby_out), 24'h1);
		chk(24'(row_packing_out), 24'h1);
		@(posedge clk_in);
		idle_mode_in <= 1'b0;
		repeat (pfwec_pkg::WAKE_CYCLES - 1) @(posedge clk_in);
		#1 chk(24'(flash_ready_out), 24'h0);
		@(posedge clk_in);
		#1 chk(24'(flash_ready_out), 24'h1);
		@(posedge clk_in);
		rst_n_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		rst_n_in <= 1'b1;
		@(posedge clk_in);
		rd(pfwec_pkg::ADDR_CONTROL, 16'h4002);
		rst_n_in <= 1'b0;
		por_n_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		rst_n_in <= 1'b1;
		por_n_in <= 1'b1;
		@(posedge clk_in);
		rd(pfwec_pkg::ADDR_CONTROL, 16'h0000);
		close_out();
	end
endmodule // program_flash_write_erase_control_bench

bind pfwec_core pfwec_checker u_chk (.*);
